/* File: design/capture_timer_pkg.sv */
// Package with register map, field layout, timing counts and types of the capture timer.
// Notes on behaviour
// - Each channel's buffer and channel register form a two-entry queue; a buffered value moves on when the channel is empty or being read.
// - Moving a buffered value into the channel register sets the channel flag and raises its event output, and the interrupt when that flag is unmasked.
// - The capture buffer has no address; software fetches captured values from the channel registers only.
// - While counting up, a counter value of zero is never captured; down counting captures the full range.
// - A capture channel stores the current counter value as a timestamp on each capture event that arrives while its flag is clear.
// - A capture event that arrives while the channel flag is still set is dropped and sets the error flag.
// - Period and pulse-width capture takes two captures per input cycle and restarts the counter on the rising edge.
// - Channel busy (bit 6) sets when the buffer is written and clears on the move or when buffer valid is cleared.
// - Count busy (bit 4) is set while a written counter value is carried over and clears one cycle before it lands.
// - Status busy (bit 3) sets when a one is written to a buffer valid flag and clears when that finishes.
// - Control B busy (bit 2) is set while a write to the second control register is carried over.
// - With the invert bit set, the incoming event is inverted before edges are detected.
// - Action 0x5 captures period in channel 0 and pulse width in channel 1; action 0x6 swaps them.
package capture_timer_pkg;

  localparam int COUNT_WIDTH = 16;
  localparam int CHANNELS = 2;
  localparam int SYNC_CYCLES = 3;
  localparam int SYNC_UNITS = 5;

  localparam logic [11:0] CTRL_A_OFFSET = 12'h000;
  localparam logic [11:0] CTRL_B_OFFSET = 12'h004;
  localparam logic [11:0] EVENT_CTRL_OFFSET = 12'h008;
  localparam logic [11:0] INT_FLAG_OFFSET = 12'h00c;
  localparam logic [11:0] SYNC_BUSY_OFFSET = 12'h010;
  localparam logic [11:0] INT_MASK_OFFSET = 12'h014;
  localparam logic [11:0] STATUS_OFFSET = 12'h018;
  localparam logic [11:0] COUNT_OFFSET = 12'h01c;
  localparam logic [11:0] CHANNEL_OFFSET = 12'h020;

  localparam int SOFTWARE_RESET_BIT_BIT = 0;
  localparam int ENABLE_BIT = 1;
  localparam int DIR_BIT = 0;
  localparam int INVERT_BIT = 4;
  localparam int ERROR_BIT = 1;
  localparam int MATCH_BASE = 4;
  localparam int VALID_BASE = 4;
  localparam int SYNC_SECOND_CONTROL_REG_BIT = 2;
  localparam int SYNC_STATUS_BIT = 3;
  localparam int SYNC_COUNT_BIT = 4;
  localparam int SYNC_CC_BIT = 6;

  localparam logic [31:0] SYNC_BUSY_RESET = 32'h0000_0000;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    act_off = 3'b000,
    act_retrigger = 3'b001,
    act_count = 3'b010,
    act_start = 3'b011,
    act_stamp = 3'b100,
    period_pulse_capture = 3'b101,
    pulse_period_capture = 3'b110,
    act_pulse_width = 3'b111
  } event_action_type;

  typedef struct packed {
    logic strobe;
    logic [COUNT_WIDTH-1:0] value;
  } capture_type;

endpackage : capture_timer_pkg

/* File: design/sync_busy_timer.sv */
// Busy tracker for one register carried between clock domains.
module sync_busy_timer #(
  parameter int CYCLES = capture_timer_pkg::SYNC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_done;

  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (abort) begin
      next_count = '0;
    end else if (start) begin
      next_count = CW'(CYCLES);
    end else if (count != '0) begin
      next_count = count - 1'b1;
      next_done = (count == CW'(1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end

  assign busy = (count != '0);

endmodule : sync_busy_timer

/* File: design/capture_queue.sv */
// Two-entry capture queue of one channel: hidden buffer in front of the channel register.
module capture_queue (
  input wire logic pclk,
  input wire logic presetn,
  input capture_timer_pkg::capture_type capture,
  input wire logic flag_set,
  input wire logic chan_read,
  input wire logic buf_clear,
  output logic [capture_timer_pkg::COUNT_WIDTH-1:0] chan_value,
  output logic buf_valid,
  output logic stored,
  output logic moved,
  output logic overflow
);

  logic [capture_timer_pkg::COUNT_WIDTH-1:0] buffer;
  logic [capture_timer_pkg::COUNT_WIDTH-1:0] next_buffer;
  logic [capture_timer_pkg::COUNT_WIDTH-1:0] next_chan_value;
  logic chan_full;
  logic next_chan_full;
  logic next_buf_valid;
  logic next_moved;
  logic next_overflow;
  logic take;

  always_comb begin
    take = capture.strobe && !flag_set;
    next_buffer = buffer;
    next_buf_valid = buf_valid;
    next_chan_value = chan_value;
    next_chan_full = chan_full;
    next_moved = 1'b0;
    next_overflow = capture.strobe && flag_set;
    if (buf_clear) begin
      next_buf_valid = 1'b0;
    end
    if (chan_read) begin
      next_chan_full = 1'b0;
    end
    if (buf_valid && !buf_clear && (!chan_full || chan_read)) begin
      next_chan_value = buffer;
      next_chan_full = 1'b1;
      next_moved = 1'b1;
      next_buf_valid = 1'b0;
    end
    if (take) begin
      next_buffer = capture.value;
      next_buf_valid = 1'b1;
    end
  end

  assign stored = take;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer <= '0;
      buf_valid <= 1'b0;
      chan_value <= '0;
      chan_full <= 1'b0;
      moved <= 1'b0;
      overflow <= 1'b0;
    end else begin
      buffer <= next_buffer;
      buf_valid <= next_buf_valid;
      chan_value <= next_chan_value;
      chan_full <= next_chan_full;
      moved <= next_moved;
      overflow <= next_overflow;
    end
  end

endmodule : capture_queue

/* File: design/capture_timer.sv */
// Capture timer top: APB registers, counter, event edge logic, queues and busy tracking.
//
// Decided for this implementation: the APB slave port.
module capture_timer #(
  parameter int CHANNELS = capture_timer_pkg::CHANNELS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_in,
  output logic [CHANNELS-1:0] capture_event_out,
  output logic irq
);

  localparam int W = capture_timer_pkg::COUNT_WIDTH;
  localparam int U = capture_timer_pkg::SYNC_UNITS;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic access;
  logic wr;
  logic rd;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic hit;
  logic [CHANNELS-1:0] chan_sel;

  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;

  ////////////////////////////////////////////////////////////////////////////////
  // State declarations.

  logic enable;
  logic enable_pending;
  logic dir_down;
  logic dir_pending;
  capture_timer_pkg::event_action_type action;
  logic invert;
  logic [31:0] int_mask;
  logic [W-1:0] count_pending;
  logic next_enable;
  logic next_enable_pending;
  logic next_dir_down;
  logic next_dir_pending;
  capture_timer_pkg::event_action_type next_action;
  logic next_invert;
  logic [31:0] next_int_mask;
  logic [W-1:0] next_count_pending;

  logic [W-1:0] counter;
  logic [W-1:0] next_counter;
  logic ev_prev;
  logic next_ev_prev;
  logic ev_now;
  logic rise;
  logic fall;
  logic restart;

  logic error_flag;
  logic next_error_flag;
  logic [CHANNELS-1:0] match_flag;
  logic [CHANNELS-1:0] next_match_flag;
  logic next_irq;
  logic [CHANNELS-1:0] next_event_out;

  logic [U-1:0] sync_start;
  logic [U-1:0] sync_busy;
  logic [U-1:0] sync_done;
  logic [U-1:0] sync_abort;
  logic [CHANNELS-1:0] cc_busy;
  logic [CHANNELS-1:0] next_cc_busy;

  capture_timer_pkg::capture_type cap [CHANNELS];
  logic [W-1:0] chan_value [CHANNELS];
  logic [CHANNELS-1:0] buf_valid;
  logic [CHANNELS-1:0] stored;
  logic [CHANNELS-1:0] moved;
  logic [CHANNELS-1:0] overflow;
  logic [CHANNELS-1:0] chan_read;
  logic [CHANNELS-1:0] buf_clear;
  logic [31:0] sync_word;
  logic [31:0] flag_word;
  logic [31:0] valid_word;
  logic [CHANNELS-1:0] want;
  logic capture_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Busy tracking. Index 0 software reset, 1 enable, 2 control B, 3 status, 4 count.

  always_comb begin
    sync_start = '0;
    sync_start[0] = wr && paddr == capture_timer_pkg::CTRL_A_OFFSET
      && pwdata[capture_timer_pkg::SOFTWARE_RESET_BIT_BIT];
    sync_start[1] = wr && paddr == capture_timer_pkg::CTRL_A_OFFSET;
    sync_start[2] = wr && paddr == capture_timer_pkg::CTRL_B_OFFSET;
    sync_start[3] = wr && paddr == capture_timer_pkg::STATUS_OFFSET
      && (|buf_clear);
    sync_start[4] = wr && paddr == capture_timer_pkg::COUNT_OFFSET;
    // A software reset cancels every transfer still in flight, so nothing stale lands after it.
    sync_abort = {U{sync_done[0]}};
    sync_abort[0] = 1'b0;
  end

  for (genvar u = 0; u < U; u++) begin : g_sync
    sync_busy_timer #(
      .CYCLES(capture_timer_pkg::SYNC_CYCLES)
    ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .start(sync_start[u]),
      .abort(sync_abort[u]),
      .busy(sync_busy[u]),
      .done(sync_done[u])
    );
  end

  always_comb begin
    sync_word = capture_timer_pkg::SYNC_BUSY_RESET;
    sync_word[capture_timer_pkg::SOFTWARE_RESET_BIT_BIT] = sync_busy[0];
    sync_word[capture_timer_pkg::ENABLE_BIT] = sync_busy[1];
    sync_word[capture_timer_pkg::SYNC_SECOND_CONTROL_REG_BIT] = sync_busy[2];
    sync_word[capture_timer_pkg::SYNC_STATUS_BIT] = sync_busy[3];
    sync_word[capture_timer_pkg::SYNC_COUNT_BIT] = sync_busy[4];
    sync_word[capture_timer_pkg::SYNC_CC_BIT] = |cc_busy;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Capture channels.

  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    assign chan_sel[c] = paddr == capture_timer_pkg::CHANNEL_OFFSET + 12'(4 * c);
    assign chan_read[c] = rd && chan_sel[c];
    assign buf_clear[c] = wr && paddr == capture_timer_pkg::STATUS_OFFSET
      && pwdata[capture_timer_pkg::VALID_BASE + c];
    assign cap[c] = '{strobe: want[c] && capture_ok, value: counter};
    assign next_cc_busy[c] = stored[c] || (cc_busy[c] && !moved[c] && !buf_clear[c]);

    capture_queue u_queue (
      .pclk(pclk),
      .presetn(presetn),
      .capture(cap[c]),
      .flag_set(match_flag[c]),
      .chan_read(chan_read[c]),
      .buf_clear(buf_clear[c]),
      .chan_value(chan_value[c]),
      .buf_valid(buf_valid[c]),
      .stored(stored[c]),
      .moved(moved[c]),
      .overflow(overflow[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event edges and capture selection.

  always_comb begin
    ev_now = event_in ^ invert;
    next_ev_prev = ev_now;
    rise = ev_now && !ev_prev;
    fall = !ev_now && ev_prev;
    want = '0;
    restart = 1'b0;
    // Zero is the value an up counter shows right after a restart, so while counting up it is never a timestamp.
    capture_ok = enable && (dir_down || counter != '0);
    case (action)
      capture_timer_pkg::act_stamp: begin
        want[0] = rise;
      end
      capture_timer_pkg::period_pulse_capture: begin
        want[0] = rise;
        want[CHANNELS-1] = fall;
        restart = rise;
      end
      capture_timer_pkg::pulse_period_capture: begin
        want[CHANNELS-1] = rise;
        want[0] = fall;
        restart = rise;
      end
      capture_timer_pkg::act_pulse_width: begin
        want[0] = fall;
        restart = rise;
      end
      capture_timer_pkg::act_retrigger: begin
        restart = rise;
      end
      default: begin
        restart = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter.

  always_comb begin
    next_counter = counter;
    if (sync_done[0]) begin
      next_counter = '0;
    end else if (sync_done[4]) begin
      next_counter = count_pending;
    end else if (enable && restart) begin
      next_counter = dir_down ? '1 : '0;
    end else if (enable && (action != capture_timer_pkg::act_count || rise)) begin
      next_counter = dir_down ? counter - 1'b1 : counter + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= '0;
      ev_prev <= 1'b0;
      cc_busy <= '0;
    end else begin
      counter <= next_counter;
      ev_prev <= next_ev_prev;
      cc_busy <= next_cc_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration. Enable, direction and count writes take effect once their busy bit drops; event control and mask writes at once.

  always_comb begin
    next_enable_pending = enable_pending;
    next_dir_pending = dir_pending;
    next_count_pending = count_pending;
    next_action = action;
    next_invert = invert;
    next_int_mask = int_mask;
    next_enable = enable;
    next_dir_down = dir_down;
    if (wr && paddr == capture_timer_pkg::CTRL_A_OFFSET) begin
      next_enable_pending = pwdata[capture_timer_pkg::ENABLE_BIT];
    end
    if (wr && paddr == capture_timer_pkg::CTRL_B_OFFSET) begin
      next_dir_pending = pwdata[capture_timer_pkg::DIR_BIT];
    end
    if (wr && paddr == capture_timer_pkg::COUNT_OFFSET) begin
      next_count_pending = pwdata[W-1:0];
    end
    if (wr && paddr == capture_timer_pkg::EVENT_CTRL_OFFSET) begin
      next_action = capture_timer_pkg::event_action_type'(pwdata[2:0]);
      next_invert = pwdata[capture_timer_pkg::INVERT_BIT];
    end
    if (wr && paddr == capture_timer_pkg::INT_MASK_OFFSET) begin
      next_int_mask = pwdata;
    end
    if (sync_done[1]) begin
      next_enable = enable_pending;
    end
    if (sync_done[2]) begin
      next_dir_down = dir_pending;
    end
    if (sync_done[0]) begin
      next_enable = 1'b0;
      next_enable_pending = 1'b0;
      next_dir_down = 1'b0;
      next_dir_pending = 1'b0;
      next_action = capture_timer_pkg::act_off;
      next_invert = 1'b0;
      next_int_mask = capture_timer_pkg::REG_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= 1'b0;
      enable_pending <= 1'b0;
      dir_down <= 1'b0;
      dir_pending <= 1'b0;
      count_pending <= '0;
      action <= capture_timer_pkg::act_off;
      invert <= 1'b0;
      int_mask <= capture_timer_pkg::REG_RESET;
    end else begin
      enable <= next_enable;
      enable_pending <= next_enable_pending;
      dir_down <= next_dir_down;
      dir_pending <= next_dir_pending;
      count_pending <= next_count_pending;
      action <= next_action;
      invert <= next_invert;
      int_mask <= next_int_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt. A hardware set in the same cycle as a clear wins.

  always_comb begin
    next_error_flag = error_flag;
    next_match_flag = match_flag;
    if (wr && paddr == capture_timer_pkg::INT_FLAG_OFFSET) begin
      next_error_flag = error_flag && !pwdata[capture_timer_pkg::ERROR_BIT];
      next_match_flag = match_flag
        & ~pwdata[capture_timer_pkg::MATCH_BASE +: CHANNELS];
    end
    next_error_flag = next_error_flag || (|overflow);
    next_match_flag = next_match_flag | moved;
    flag_word = '0;
    flag_word[capture_timer_pkg::ERROR_BIT] = next_error_flag;
    flag_word[capture_timer_pkg::MATCH_BASE +: CHANNELS] = next_match_flag;
    next_irq = |(flag_word & next_int_mask);
    next_event_out = moved;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_flag <= 1'b0;
      match_flag <= '0;
      irq <= 1'b0;
      capture_event_out <= '0;
    end else begin
      error_flag <= next_error_flag;
      match_flag <= next_match_flag;
      irq <= next_irq;
      capture_event_out <= next_event_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data. The reply is prepared in the setup cycle, so there are no wait states.

  always_comb begin
    next_prdata = '0;
    hit = 1'b1;
    valid_word = '0;
    valid_word[capture_timer_pkg::VALID_BASE +: CHANNELS] = buf_valid;
    case (paddr)
      capture_timer_pkg::CTRL_A_OFFSET: next_prdata[capture_timer_pkg::ENABLE_BIT] = enable;
      capture_timer_pkg::CTRL_B_OFFSET: next_prdata[capture_timer_pkg::DIR_BIT] = dir_down;
      capture_timer_pkg::EVENT_CTRL_OFFSET: begin
        next_prdata[2:0] = action;
        next_prdata[capture_timer_pkg::INVERT_BIT] = invert;
      end
      capture_timer_pkg::INT_FLAG_OFFSET: begin
        next_prdata[capture_timer_pkg::ERROR_BIT] = error_flag;
        next_prdata[capture_timer_pkg::MATCH_BASE +: CHANNELS] = match_flag;
      end
      capture_timer_pkg::SYNC_BUSY_OFFSET: next_prdata = sync_word;
      capture_timer_pkg::INT_MASK_OFFSET: next_prdata = int_mask;
      capture_timer_pkg::STATUS_OFFSET: next_prdata = valid_word;
      capture_timer_pkg::COUNT_OFFSET: next_prdata[W-1:0] = counter;
      default: begin
        // The hidden buffers have no address; anything unmapped errors and reads zero.
        hit = |chan_sel;
        for (int c = 0; c < CHANNELS; c++) begin
          if (chan_sel[c]) begin
            next_prdata[W-1:0] = chan_value[c];
          end
        end
      end
    endcase
    // Write replies carry no data, so a stale register value never shows on the bus.
    if (pwrite) begin
      next_prdata = '0;
    end
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule : capture_timer

/* File: bench/capture_timer_chk.sv */
// Port checker for the capture timer, bound to its top module.
module capture_timer_chk #(
  parameter int CHANNELS = capture_timer_pkg::CHANNELS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic event_in,
  input wire logic [CHANNELS-1:0] capture_event_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  ////////////////////////////////////////
  property p_ready_after_setup;
    setup |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  property p_ready_single;
    pready |=> !pready;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("ready held too long");
  property p_ready_needs_setup;
    !setup |=> !pready;
  endproperty
  a_ready_needs_setup: assert property (p_ready_needs_setup) else $error("ready without setup");
  property p_unmapped_err;
    setup && paddr >= 12'h028 |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped not refused");
  property p_mapped_ok;
    setup && paddr < 12'h028 && paddr[1:0] == 2'h0 |=> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");
  property p_write_zero;
    setup && pwrite |=> prdata == 32'h0;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("read data during write");
  property p_pulse_single;
    capture_event_out != '0 |=> (capture_event_out & $past(capture_event_out)) == '0;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("event pulse too long");
  property p_irq_fall_by_write;
    $fell(irq) |-> $past(psel && pwrite) || $past(psel && pwrite, 2);
  endproperty
  a_irq_fall_by_write: assert property (p_irq_fall_by_write) else $error("irq fell by itself");
  property p_reset_quiet;
    $rose(presetn) |-> !pready && !irq && capture_event_out == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  c_capture: cover property (capture_event_out[0]);
  c_error: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule : capture_timer_chk

bind capture_timer capture_timer_chk #(.CHANNELS(CHANNELS)) chk_u (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .event_in(event_in), .capture_event_out(capture_event_out), .irq(irq));

/* File: bench/event_source.sv */
// Event routing network model that drives the capture event level.
module event_source (
  input wire logic pclk,
  output logic event_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int now = 0;
  int last_rise = 0;
  int last_fall = 0;
  initial event_in = 1'b0;
  always @(posedge pclk) now <= now + 1;
  ////////////////////////////////////////
  // Edge times are kept so the bench can derive expected counts without the design.
  task automatic drive(input logic level);
    @(posedge pclk);
    event_in <= level;
    if (level) last_rise = now;
    else last_fall = now;
  endtask : drive
endmodule : event_source

/* File: bench/timer_capture_sync_busy_tb.sv */
// Self-checking bench for the capture timer.
module timer_capture_sync_busy_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] busy;
  } row_type;
  row_type rows [5] = '{'{12'h000, 32'h1, 32'h3}, '{12'h000, 32'h2, 32'h2},
    '{12'h004, 32'h0, 32'h4}, '{12'h01c, 32'h0, 32'h10}, '{12'h018, 32'h30, 32'h8}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v1;
  logic [1:0] capture_event_out;
  wire event_in;
  int err_total = 0;
  int n_checks = 0;
  int r1;
  capture_timer dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in(event_in), .capture_event_out(capture_event_out), .irq(irq));
  event_source src_u (.pclk(pclk), .event_in(event_in));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic timed_out;
    err_total++;
    tally_and_finish();
  endtask : timed_out
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) timed_out();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask : rchk
  task automatic wait_cap(input int c);
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge pclk);
      if (capture_event_out[c] === 1'b1) break;
    end
    if (i == 100) timed_out();
  endtask : wait_cap
  task automatic poll_idle;
    int i;
    for (i = 0; i < 20; i++) begin
      apb(1'b0, 12'h010, 32'h0);
      if (rd === 32'h0) break;
    end
    if (i == 20) timed_out();
  endtask : poll_idle
  // Emptying both channels keeps a stale value from parking a new capture in the buffer.
  task automatic drain;
    apb(1'b0, 12'h020, 32'h0);
    apb(1'b0, 12'h024, 32'h0);
    apb(1'b1, 12'h00c, 32'h32);
  endtask : drain
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h010, 32'hffffffff, 32'h0);
    apb(1'b0, 12'h028, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h010, 32'hffffffff);
    rchk(12'h010, 32'hffffffff, 32'h0);
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, rows[k].a, rows[k].d);
      rchk(12'h010, 32'hffffffff, rows[k].busy);
      poll_idle();
    end
    $display("test busy done");
    apb(1'b1, 12'h014, 32'h10);
    apb(1'b1, 12'h008, 32'h4);
    src_u.drive(1'b1);
    wait_cap(0);
    r1 = src_u.last_rise;
    src_u.drive(1'b0);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h1);
    src_u.drive(1'b1);
    src_u.drive(1'b0);
    repeat (4) @(posedge pclk);
    rchk(12'h00c, 32'h12, 32'h12);
    apb(1'b0, 12'h020, 32'h0);
    v1 = rd;
    apb(1'b1, 12'h00c, 32'h32);
    rchk(12'h00c, 32'h12, 32'h0);
    chk(irq, 32'h0);
    src_u.drive(1'b1);
    wait_cap(0);
    src_u.drive(1'b0);
    apb(1'b0, 12'h020, 32'h0);
    chk({16'h0, rd[15:0] - v1[15:0]}, 32'(src_u.last_rise - r1));
    apb(1'b1, 12'h014, 32'h0);
    rchk(12'h00c, 32'h10, 32'h10);
    chk(irq, 32'h0);
    apb(1'b1, 12'h014, 32'h10);
    rchk(12'h00c, 32'h10, 32'h10);
    chk(irq, 32'h1);
    $display("test stamp done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 12'h008, k ? 32'h6 : 32'h5);
      drain();
      src_u.drive(1'b1);
      repeat (5) @(posedge pclk);
      src_u.drive(1'b0);
      wait_cap(1 - k);
      apb(1'b0, 12'h020 + 12'(4 * (1 - k)), 32'h0);
      v1 = rd;
      apb(1'b0, 12'h020 + 12'(4 * k), 32'h0);
      apb(1'b1, 12'h00c, 32'h32);
      src_u.drive(1'b1);
      wait_cap(k);
      apb(1'b0, 12'h020 + 12'(4 * k), 32'h0);
      chk({16'h0, rd[15:0] - v1[15:0]}, 32'(src_u.last_rise - src_u.last_fall));
      src_u.drive(1'b0);
    end
    $display("test period done");
    drain();
    apb(1'b1, 12'h008, 32'h14);
    wait_cap(0);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h1);
    $display("test invert done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(irq, 32'h0);
    rchk(12'h014, 32'hffffffff, 32'h0);
    rchk(12'h00c, 32'hffffffff, 32'h0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : timer_capture_sync_busy_tb
